// file: logic/rur_pkg.sv
// shared constants, state codes and register layout of the remote upgrade register set
package rur_pkg;
	localparam int  CTL_W          = 39;
	localparam int  STAT_W         = 32;
	localparam int  SYNC_W         = 12;
	localparam int  CAUSE_W        = 5;
	// control register field positions
	localparam int  CTL_RSV_HI     = 38;
	localparam int  CTL_EARLY_DONE = 37;
	localparam int  CTL_START_OSC  = 36;
	localparam int  CTL_WATCHDOG_ENABLE      = 35;
	localparam int  CTL_RSV_LO     = 34;
	localparam int  CTL_ADDR_HI    = 33;
	localparam int  CTL_ADDR_LO    = 12;
	localparam int  CTL_WD_HI      = 11;
	localparam int  CTL_WD_LO      = 0;
	localparam int  ADDR_MSB_W     = 22;
	localparam int  WD_MSB_W       = 12;
	// derived values
	localparam logic [16:0] WD_LOW_PATTERN  = 17'h00008;
	localparam logic [1:0]  ADDR_LOW_BITS   = 2'h0;
	localparam logic [23:0] AS_FACTORY_ADDR = 24'h000000;
	localparam logic [23:0] AP_FACTORY_ADDR = 24'h010000;
	// cause bits, higher index wins a tie
	localparam int  CAUSE_PIN_RESET  = 4;
	localparam int  CAUSE_CRC        = 3;
	localparam int  CAUSE_STATUS_LOW = 2;
	localparam int  CAUSE_WATCHDOG   = 1;
	localparam int  CAUSE_FABRIC     = 0;
	localparam logic [CAUSE_W-1:0] CAUSE_FABRIC_ONLY = 5'h01;
	localparam logic [CAUSE_W-1:0] CAUSE_NONE        = 5'h00;

	typedef enum logic [1:0]
	{
		MS_FACTORY = 2'h1,
		MS_APP     = 2'h2
	} rur_ms_t;

	typedef struct packed
	{
		logic                shift_clock;
		logic                shift_mode;
		logic                capture_mode;
		logic                read_status;
		logic                shift_data;
		logic                remote_mode;
		logic                scheme_parallel;
		logic [CAUSE_W-1:0]  events;
	} rur_pins_t;

	typedef struct packed
	{
		logic [CTL_W-1:0]    shift_reg;
		logic [CTL_W-1:0]    upgrade_update;
		logic [CTL_W-1:0]    upgrade_control;
		logic [STAT_W-1:0]   upgrade_status;
		rur_ms_t             master;
		logic                shift_clock_prev;
		logic [CAUSE_W-1:0]  events_prev;
	} rur_state_t;
endpackage

// file: logic/rur_sync.sv
// two flip-flop synchroniser for a vector of outside levels
module rur_sync
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             clk_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta;

	for (genvar i = 0; i < WIDTH; i++)
	begin : g_bit
		always_ff @(posedge clk_i)
		begin
			meta[i] <= d_i[i];
			q_o[i]  <= meta[i];
		end
	end
endmodule

// file: logic/rur_top.sv
// remote upgrade register set: shift, update, control and status registers
// Contract
// - shift register is the only path to write or sample the other registers; upgrade_status_o also exposes the status register directly
// - update writes allowed in remote mode from factory only, blocked for applications
// - read in application configuration loads control register into shift register
// - reconfiguration start copies update register into control register; only a fabric trigger from factory does here, others load factory_ctl
// - read in factory configuration loads update register into shift register
// - every reconfiguration writes status register with its cause
// - capture cycle loads status register into shift register
// - control and status registers run on oscillator or user configuration clock
// - shift and update registers run on shift clock, at most its maximum rate
// - serial scheme clears control address bits at power up
// - parallel scheme presets control address to default factory address
// - factory configuration in remote mode may write the update register
// - control layout: 38 rsv, 37 early done, 36 osc, 35 wd enable, 34 rsv, address, timeout
// - watchdog count is timeout field followed by fixed 17-bit pattern
// - boot address is 22-bit field followed by two zero bits
// - watchdog enable bit arms watchdog for next application
// - oscillator select bit drives startup machine from internal oscillator
// - early done check bit enables early done checking
// - status written on status line low, crc error, watchdog timeout, configuration reset
module rur_top
(
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        upgrade_shift_clock_i,
	input  wire logic        shift_mode_i,
	input  wire logic        capture_mode_i,
	input  wire logic        read_status_i,
	input  wire logic        shift_data_i,
	input  wire logic        remote_mode_i,
	input  wire logic        scheme_parallel_i,
	input  wire logic        configuration_status_line_b_i,
	input  wire logic        crc_error_i,
	input  wire logic        watchdog_timeout_i,
	input  wire logic        configuration_reset_line_b_i,
	input  wire logic        fabric_reconfig_b_i,
	input  wire logic        factory_boot_override_i,
	input  wire logic [23:0] factory_boot_address_i,
	output logic             shift_data_o,
	output logic             factory_mode_o,
	output logic [23:0]      boot_address_o,
	output logic [28:0]      watchdog_count_o,
	output logic             watchdog_enable_o,
	output logic             startup_osc_select_o,
	output logic             early_done_check_o,
	output logic [31:0]      upgrade_status_o
);
	// ****************************************
	// input synchronisation
	// ****************************************
	rur_pkg::rur_pins_t raw_pins;
	rur_pkg::rur_pins_t pins;

	assign raw_pins.shift_clock     = upgrade_shift_clock_i;
	assign raw_pins.shift_mode      = shift_mode_i;
	assign raw_pins.capture_mode    = capture_mode_i;
	assign raw_pins.read_status     = read_status_i;
	assign raw_pins.shift_data      = shift_data_i;
	assign raw_pins.remote_mode     = remote_mode_i;
	assign raw_pins.scheme_parallel = scheme_parallel_i;
	assign raw_pins.events          = {~configuration_reset_line_b_i, crc_error_i,
	                                   ~configuration_status_line_b_i, watchdog_timeout_i, ~fabric_reconfig_b_i};

	rur_sync #(.WIDTH(rur_pkg::SYNC_W)) u_sync
	(
		.clk_i (clk_i),
		.d_i   (raw_pins),
		.q_o   (pins)
	);

	// scan-host override word is quasi-static but still comes from outside the clock
	logic [24:0]                    boot_sync_q;

	rur_sync #(.WIDTH(25)) u_boot_sync
	(
		.clk_i (clk_i),
		.d_i   ({factory_boot_override_i, factory_boot_address_i}),
		.q_o   (boot_sync_q)
	);

	// ****************************************
	// state and derived strobes
	// ****************************************
	rur_pkg::rur_state_t            st;
	rur_pkg::rur_state_t            next_st;
	logic                           shift_rise;
	logic [rur_pkg::CAUSE_W-1:0]    event_rise;
	logic [rur_pkg::CAUSE_W-1:0]    cause;
	logic [23:0]                    factory_addr;
	logic [rur_pkg::CTL_W-1:0]      factory_ctl;

	assign shift_rise = pins.shift_clock & ~st.shift_clock_prev;
	assign event_rise = pins.events & ~st.events_prev;

	// highest set bit alone survives a tie
	always_comb
	begin
		cause = rur_pkg::CAUSE_NONE;
		for (int i = 0; i < rur_pkg::CAUSE_W; i++)
		begin
			if (event_rise[i])
			begin
				cause = rur_pkg::CAUSE_NONE;
				cause[i] = 1'b1;
			end
		end
	end

	// default factory address, replaceable by the scan host in the parallel scheme only
	always_comb
	begin
		factory_addr = rur_pkg::AS_FACTORY_ADDR;
		if (pins.scheme_parallel)
		begin
			factory_addr = boot_sync_q[24] ? boot_sync_q[23:0]
			                               : rur_pkg::AP_FACTORY_ADDR;
		end
		factory_ctl = '0;
		factory_ctl[rur_pkg::CTL_ADDR_HI:rur_pkg::CTL_ADDR_LO] = factory_addr[23:2];
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		next_st = st;
		next_st.shift_clock_prev = pins.shift_clock;
		next_st.events_prev      = pins.events;
		if (shift_rise)
		begin
			if (pins.shift_mode)
			begin
				next_st.shift_reg = {pins.shift_data, st.shift_reg[rur_pkg::CTL_W-1:1]};
			end
			else if (pins.capture_mode)
			begin
				if (pins.read_status)
				begin
					next_st.shift_reg = {7'h00, st.upgrade_status};
				end
				else if (st.master == rur_pkg::MS_FACTORY)
				begin
					next_st.shift_reg = st.upgrade_update;
				end
				else
				begin
					next_st.shift_reg = st.upgrade_control;
				end
			end
			else if (pins.remote_mode && st.master == rur_pkg::MS_FACTORY)
			begin
				next_st.upgrade_update = st.shift_reg;
			end
		end
		if (|event_rise)
		begin
			next_st.upgrade_status = {st.master, 1'b0, cause, boot_address_o};
			if (st.master == rur_pkg::MS_FACTORY && cause == rur_pkg::CAUSE_FABRIC_ONLY)
			begin
				next_st.master          = rur_pkg::MS_APP;
				next_st.upgrade_control = st.upgrade_update;
			end
			else
			begin
				next_st.master          = rur_pkg::MS_FACTORY;
				next_st.upgrade_control = factory_ctl;
			end
		end
	end

	// clk_i stands for the oscillator or the user configuration clock
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			st                  <= '0;
			st.master           <= rur_pkg::MS_FACTORY;
			st.upgrade_control  <= factory_ctl;
			st.shift_clock_prev <= 1'b1;
			st.events_prev      <= {rur_pkg::CAUSE_W{1'b1}};
		end
		else
		begin
			st <= next_st;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign shift_data_o         = st.shift_reg[0];
	assign factory_mode_o       = (st.master == rur_pkg::MS_FACTORY);
	assign boot_address_o       = {st.upgrade_control[rur_pkg::CTL_ADDR_HI:rur_pkg::CTL_ADDR_LO],
	                               rur_pkg::ADDR_LOW_BITS};
	assign watchdog_count_o     = {st.upgrade_control[rur_pkg::CTL_WD_HI:rur_pkg::CTL_WD_LO],
	                               rur_pkg::WD_LOW_PATTERN};
	assign watchdog_enable_o    = st.upgrade_control[rur_pkg::CTL_WATCHDOG_ENABLE];
	assign startup_osc_select_o = st.upgrade_control[rur_pkg::CTL_START_OSC];
	assign early_done_check_o   = st.upgrade_control[rur_pkg::CTL_EARLY_DONE];
	assign upgrade_status_o     = st.upgrade_status;

	// ****************************************
	// assertions
	// ****************************************
	sequence s_shift_step;
		shift_rise && pins.shift_mode;
	endsequence

	sequence s_update_step;
		shift_rise && !pins.shift_mode && !pins.capture_mode;
	endsequence

	sequence s_read_step;
		shift_rise && !pins.shift_mode && pins.capture_mode && !pins.read_status;
	endsequence

	a_shift_moves: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_shift_step |=> st.shift_reg == {$past(pins.shift_data), $past(st.shift_reg[rur_pkg::CTL_W-1:1])})
		else $error("shift register did not move one bit");
	a_update_blocked: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_update_step and (st.master == rur_pkg::MS_APP) |=> $stable(st.upgrade_update))
		else $error("application changed the update register");
	a_update_taken: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_update_step and (st.master == rur_pkg::MS_FACTORY) and pins.remote_mode
		|=> st.upgrade_update == $past(st.shift_reg))
		else $error("factory update write lost");
	a_read_control: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_read_step and (st.master == rur_pkg::MS_APP) |=> st.shift_reg == $past(st.upgrade_control))
		else $error("application read did not load control");
	a_read_update: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_read_step and (st.master == rur_pkg::MS_FACTORY) |=> st.shift_reg == $past(st.upgrade_update))
		else $error("factory read did not load update");
	a_capture_status: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		shift_rise && !pins.shift_mode && pins.capture_mode && pins.read_status
		|=> st.shift_reg[rur_pkg::STAT_W-1:0] == $past(st.upgrade_status))
		else $error("capture did not load status");
	a_reconfig_copy: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(st.master == rur_pkg::MS_FACTORY) && (cause == rur_pkg::CAUSE_FABRIC_ONLY)
		|=> st.upgrade_control == $past(st.upgrade_update) ##1 watchdog_enable_o == st.upgrade_control[rur_pkg::CTL_WATCHDOG_ENABLE])
		else $error("reconfiguration did not copy update into control");
	a_status_cause: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(|event_rise) |=> st.upgrade_status[23:0] == $past(boot_address_o) && $onehot(st.upgrade_status[28:24]))
		else $error("status not written on reconfiguration");
	a_reset_address: assert property (@(posedge clk_i)
		$rose(rst_b_i) && pins.scheme_parallel && !boot_sync_q[24] |-> boot_address_o == rur_pkg::AP_FACTORY_ADDR)
		else $error("parallel scheme factory address wrong after reset");
	a_count_form: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		watchdog_count_o[16:0] == rur_pkg::WD_LOW_PATTERN
		&& watchdog_count_o[28:17] == st.upgrade_control[rur_pkg::CTL_WD_HI:rur_pkg::CTL_WD_LO])
		else $error("watchdog count badly formed");

	// ****************************************
	// reset, reconfiguration, remote gate and hold assertions
	// ****************************************
	sequence s_event_step;
		(|event_rise);
	endsequence

	sequence s_app_entry;
		(|event_rise) && (st.master == rur_pkg::MS_FACTORY) && (cause == rur_pkg::CAUSE_FABRIC_ONLY);
	endsequence

	sequence s_factory_entry;
		(|event_rise) && !((st.master == rur_pkg::MS_FACTORY) && (cause == rur_pkg::CAUSE_FABRIC_ONLY));
	endsequence

	a_app_entry: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_app_entry |=> st.master == rur_pkg::MS_APP)
		else $error("fabric trigger did not enter application");

	a_option_bits: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_app_entry |=> {early_done_check_o, startup_osc_select_o, watchdog_enable_o}
		    == $past(st.upgrade_update[rur_pkg::CTL_EARLY_DONE:rur_pkg::CTL_WATCHDOG_ENABLE]))
		else $error("option bits not taken from update register");

	a_factory_return: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_factory_entry
		|=> st.master == rur_pkg::MS_FACTORY && st.upgrade_control == $past(factory_ctl))
		else $error("error cause did not return to factory address");

	a_status_master: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_event_step |=> st.upgrade_status[rur_pkg::STAT_W-1:rur_pkg::STAT_W-2] == $past(st.master))
		else $error("status lost the master state");

	a_remote_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_update_step and !pins.remote_mode |=> $stable(st.upgrade_update))
		else $error("update written outside remote mode");

	a_quiet_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!shift_rise && !(|event_rise)
		|=> $stable(st.shift_reg) && $stable(st.upgrade_update) && $stable(st.upgrade_control)
		    && $stable(st.upgrade_status))
		else $error("registers changed without shift clock or cause");

	a_reset_serial: assert property (@(posedge clk_i)
		$rose(rst_b_i) && !pins.scheme_parallel |-> boot_address_o == rur_pkg::AS_FACTORY_ADDR)
		else $error("serial scheme factory address not zero after reset");

	a_reset_state: assert property (@(posedge clk_i)
		$rose(rst_b_i) |-> factory_mode_o && st.shift_reg == '0 && st.upgrade_update == '0
		    && st.upgrade_status == '0)
		else $error("reset did not clear the register set");
endmodule

// file: test/rur_fabric_model.sv
// fabric-side factory logic model that drives the upgrade shift interface
module rur_fabric_model
(
	input  wire logic clk_i,
	input  wire logic shift_data_i,
	output logic      shift_clock_o,
	output logic      shift_mode_o,
	output logic      capture_mode_o,
	output logic      read_status_o,
	output logic      shift_data_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		shift_clock_o  = 1'b0;
		shift_mode_o   = 1'b1;
		capture_mode_o = 1'b0;
		read_status_o  = 1'b0;
		shift_data_o   = 1'b0;
	end
	// one pulse: 4 cycles low, 4 high, clock stays low between frames
	task automatic pulse(output logic s);
		repeat (2) @(negedge clk_i);
		s = shift_data_i;
		repeat (2) @(negedge clk_i);
		shift_clock_o = 1'b1;
		repeat (4) @(negedge clk_i);
		shift_clock_o = 1'b0;
	endtask
	task automatic shift_word(input logic [38:0] w, output logic [38:0] r);
		shift_mode_o = 1'b1;
		for (int i = 0; i < 39; i++)
		begin
			shift_data_o = w[i];
			pulse(r[i]);
		end
		// released data line shows the inverse of its last bit
		shift_data_o = ~w[38];
	endtask
	// one update (cap low) or capture (cap high) pulse, shift mode off
	task automatic op(input logic cap, input logic rs);
		logic s;
		shift_mode_o   = 1'b0;
		capture_mode_o = cap;
		read_status_o  = rs;
		pulse(s);
	endtask
endmodule

// file: test/rur_top_bench.sv
// self-checking bench for the remote upgrade register set
module rur_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i;
	logic        rst_b_i;
	logic        sclk, smode, cmode, rstat, sdi, sdo, remote, ap, ovr, factory, wde, osc, early;
	logic [4:0]  ev;
	logic [23:0] ovr_addr, boot;
	logic [28:0] wdc;
	logic [31:0] stat, exp_stat;
	logic [38:0] r, w;
	logic [38:0] rows [4] = '{39'h7f_ffff_ffff, 39'h00_0000_1001, 39'h55_5a5a_c3c3, 39'h2a_a5a5_3c3c};
	int          mismatches = 0;
	int          tests_run = 0;

	rur_fabric_model i_fab (.clk_i(clk_i), .shift_data_i(sdo), .shift_clock_o(sclk), .shift_mode_o(smode),
		.capture_mode_o(cmode), .read_status_o(rstat), .shift_data_o(sdi));
	rur_top i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .upgrade_shift_clock_i(sclk), .shift_mode_i(smode),
		.capture_mode_i(cmode), .read_status_i(rstat), .shift_data_i(sdi), .remote_mode_i(remote),
		.scheme_parallel_i(ap), .configuration_status_line_b_i(~ev[2]), .crc_error_i(ev[3]),
		.watchdog_timeout_i(ev[1]), .configuration_reset_line_b_i(~ev[4]), .fabric_reconfig_b_i(~ev[0]),
		.factory_boot_override_i(ovr), .factory_boot_address_i(ovr_addr), .shift_data_o(sdo),
		.factory_mode_o(factory), .boot_address_o(boot), .watchdog_count_o(wdc), .watchdog_enable_o(wde),
		.startup_osc_select_o(osc), .early_done_check_o(early), .upgrade_status_o(stat));

	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input string name, input logic [38:0] seen, input logic [38:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cause(input int k);
		@(negedge clk_i);
		ev[k] = 1'b1;
		repeat (6) @(negedge clk_i);
		ev = 5'h00;
		repeat (6) @(negedge clk_i);
	endtask
	task automatic do_reset(input logic par);
		@(negedge clk_i);
		rst_b_i = 1'b0;
		ap = par;
		repeat (6) @(negedge clk_i);
		rst_b_i = 1'b1;
		repeat (3) @(negedge clk_i);
	endtask
	task automatic read_word(input logic rs, input logic [38:0] din);
		i_fab.op(1'b1, rs);
		i_fab.shift_word(din, r);
	endtask

	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	initial
	begin
		repeat (100000) @(posedge clk_i);
		mismatches++;
		end_of_test();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		{rst_b_i, ap, ovr, remote, ev, ovr_addr} = {1'b0, 1'b0, 1'b0, 1'b1, 5'h00, 24'h000000};
		do_reset(1'b0);
		check("boot_address", boot, 24'h000000);
		check("factory_mode", factory, 1'h1);
		check("watchdog_count", wdc, {12'h000, rur_pkg::WD_LOW_PATTERN});
		for (int k = 0; k < 4; k++)
		begin
			w = rows[k];
			i_fab.shift_word(w, r);
			i_fab.op(1'b0, 1'b0);
			read_word(1'b0, 39'h00_0000_0000);
			check("update_read", r, w);
			cause(0);
			check("status_word", stat, {2'h1, 1'h0, 5'h01, 24'h000000});
			check("factory_mode", factory, 1'h0);
			check("boot_address", boot, {w[33:12], 2'h0});
			check("watchdog_count", wdc, {w[11:0], rur_pkg::WD_LOW_PATTERN});
			check("option_bits", {early, osc, wde}, w[37:35]);
			read_word(1'b0, ~w);
			check("control_read", r, w);
			i_fab.op(1'b0, 1'b0);
			cause(k + 1);
			check("factory_mode", factory, 1'h1);
			check("boot_address", boot, 24'h000000);
			exp_stat = {2'h2, 1'h0, 5'h01 << (k + 1), w[33:12], 2'h0};
			check("status_word", stat, exp_stat);
			read_word(1'b1, 39'h00_0000_0000);
			check("status_cause", {r[38:32], r[29:24]}, {7'h00, 1'h0, 5'h01 << (k + 1)});
			check("status_read", r[31:0], exp_stat);
			read_word(1'b0, 39'h00_0000_0000);
			check("update_kept", r, w);
		end
		remote = 1'b0;
		i_fab.shift_word(39'h12_3456_789a, r);
		i_fab.op(1'b0, 1'b0);
		read_word(1'b0, 39'h00_0000_0000);
		check("update_no_remote", r, rows[3]);
		remote = 1'b1;
		do_reset(1'b1);
		check("boot_address", boot, 24'h010000);
		ovr = 1'b1;
		ovr_addr = 24'h2abcd4;
		do_reset(1'b1);
		check("boot_address", boot, 24'h2abcd4);
		end_of_test();
	end
endmodule
